// [rtl/iic_map.vh]
// Register map, field positions, reset values and codes of the input idle configuration block
`ifndef IIC_MAP_VH
`define IIC_MAP_VH

// ----------------------------------------
// Register addresses (word addressed)
// ----------------------------------------
`define IIC_ADDR_W            15
`define IIC_DATA_W            16
`define IIC_ADDR_RUN_CONTROL  15'h0010
`define IIC_ADDR_IDLE_STATE   15'h0020
`define IIC_ADDR_PAIRING_CFG  15'h0021

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IIC_RUN_SELECT_BIT    0
`define IIC_SLOT_LEN_LSB      8
`define IIC_SLOT_LEN_MSB      11
`define IIC_PAIR4_CODE_LSB    12
`define IIC_PAIR4_CODE_MSB    15
`define IIC_PAIR3_CODE_LSB    8
`define IIC_PAIR3_CODE_MSB    11
`define IIC_PAIR2_CODE_LSB    4
`define IIC_PAIR2_CODE_MSB    7
`define IIC_PAIR1_CODE_LSB    0
`define IIC_PAIR1_CODE_MSB    3
`define IIC_BIAS2_CODE_LSB    6
`define IIC_BIAS2_CODE_MSB    7
`define IIC_BIAS1_CODE_LSB    4
`define IIC_BIAS1_CODE_MSB    5
`define IIC_DIFF_LSB          0
`define IIC_DIFF_MSB          3

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define IIC_RST_RUN_CONTROL   16'h0000
`define IIC_RST_IDLE_STATE    16'h0000
`define IIC_RST_PAIRING_CFG   16'h0000
`define IIC_MASK_RUN_CONTROL  16'h0f01
`define IIC_MASK_IDLE_STATE   16'hffff
`define IIC_MASK_PAIRING_CFG  16'h00ff

// ----------------------------------------
// Codes
// ----------------------------------------
`define IIC_SLOT_LEN_MAX      4'hb
`define IIC_IDLE_FLOAT        4'h0
`define IIC_IDLE_SHORT_FLOAT  4'h1
`define IIC_IDLE_BOTH_B1      4'h2
`define IIC_IDLE_BOTH_B2      4'h3
`define IIC_IDLE_ODD_B1       4'h4
`define IIC_IDLE_ODD_B1_EV_B2 4'h5
`define IIC_IDLE_ODD_B2       4'h6
`define IIC_IDLE_ODD_B2_EV_B1 4'h7
`define IIC_IDLE_EV_B1        4'h8
`define IIC_IDLE_EV_B2        4'h9
`define IIC_BIAS_SUPPLY       2'h0
`define IIC_BIAS_GROUND       2'h1
`define IIC_BIAS_FLOAT        2'h2

`endif

// [rtl/iic_pair_decode.v]
// Idle-state decoder for one input pair
`timescale 1ns/1ps
`include "iic_map.vh"

module iic_pair_decode (
  input  wire [3:0] i_code,
  input  wire       i_diff,
  output reg        o_odd_b1,
  output reg        o_odd_b2,
  output reg        o_even_b1,
  output reg        o_even_b2,
  output reg        o_short
);

  // ----------------------------------------
  // Code decode
  // ----------------------------------------
  always @* begin
    o_odd_b1  = 1'b0;
    o_odd_b2  = 1'b0;
    o_even_b1 = 1'b0;
    o_even_b2 = 1'b0;
    o_short   = 1'b0;
    case (i_code)
      `IIC_IDLE_FLOAT: begin
        o_short = 1'b0;
      end
      `IIC_IDLE_SHORT_FLOAT: begin
        o_short = i_diff;
      end
      `IIC_IDLE_BOTH_B1: begin
        o_odd_b1  = 1'b1;
        o_even_b1 = 1'b1;
        o_short   = i_diff;
      end
      `IIC_IDLE_BOTH_B2: begin
        o_odd_b2  = 1'b1;
        o_even_b2 = 1'b1;
        o_short   = i_diff;
      end
      `IIC_IDLE_ODD_B1: begin
        o_odd_b1 = 1'b1;
      end
      `IIC_IDLE_ODD_B1_EV_B2: begin
        o_odd_b1  = 1'b1;
        o_even_b2 = 1'b1;
      end
      `IIC_IDLE_ODD_B2: begin
        o_odd_b2 = 1'b1;
      end
      `IIC_IDLE_ODD_B2_EV_B1: begin
        o_odd_b2  = 1'b1;
        o_even_b1 = 1'b1;
      end
      `IIC_IDLE_EV_B1: begin
        o_even_b1 = 1'b1;
      end
      `IIC_IDLE_EV_B2: begin
        o_even_b2 = 1'b1;
      end
      default: begin
        // Undefined codes float both inputs, the safe analog state
        o_short = 1'b0;
      end
    endcase
  end

endmodule

// [rtl/iic_bias_decode.v]
// Idle-state decoder for one bias node
`timescale 1ns/1ps
`include "iic_map.vh"

module iic_bias_decode (
  input  wire [1:0] i_code,
  output reg        o_to_supply,
  output reg        o_to_ground
);

  // ----------------------------------------
  // Code decode
  // ----------------------------------------
  always @* begin
    o_to_supply = 1'b0;
    o_to_ground = 1'b0;
    case (i_code)
      `IIC_BIAS_SUPPLY: o_to_supply = 1'b1;
      `IIC_BIAS_GROUND: o_to_ground = 1'b1;
      `IIC_BIAS_FLOAT:  o_to_supply = 1'b0;
      default:          o_to_ground = 1'b0;
    endcase
  end

endmodule

// [rtl/iic_regs.v]
// Run control and input idle configuration registers with switch-control decode
`timescale 1ns/1ps
`include "iic_map.vh"

// Contract
// - A one-bit run select chooses standby when clear and runs the enabled time slots when set, resetting to standby.
// - Bits [15:12] of the idle register hold pair four's idle code, where 0x0 floats both inputs, reset 0x0.
// - Idle code 0x1 shorts the pair's inputs together while floating, only when that pair is differential.
// - Code 0x2 ties both inputs to bias node one, 0x3 to bias node two, also shorted when differential.
// - Codes 0x4 to 0x9 tie the odd and even inputs separately to bias node one, two or leave them floating.
// - Bits [11:8] of the idle register hold pair three's idle code with the same encoding, reset zero.
// - Bits [7:4] of the idle register hold pair two's idle code with the same encoding, reset zero.
// - Bits [3:0] of the idle register hold pair one's idle code with the same encoding, reset zero.
// - Bits [7:6] of the pairing register set bias node two in idle: 0 supply, 1 ground, 2 floating.
// - Bits [5:4] of the pairing register set bias node one in idle with the same encoding.
// - Bit 3 of the pairing register makes inputs seven and eight a differential pair when set.
// - Bit 2 of the pairing register makes inputs five and six a differential pair when set.
// - Bit 1 of the pairing register makes inputs three and four a differential pair when set.
// - Bit 0 of the pairing register makes inputs one and two a differential pair when set.
// - Bits [11:8] of the run control register give the count of slots per period less one, 0 to 0xb.
module iic_regs #(
  parameter PAIRS  = 4,
  parameter ADDR_W = `IIC_ADDR_W,
  parameter DATA_W = `IIC_DATA_W
) (
  input  wire              i_mclk,
  input  wire              i_rst,
  input  wire              i_wr_en,
  input  wire              i_rd_en,
  input  wire [ADDR_W-1:0] i_addr,
  input  wire [DATA_W-1:0] i_wr_data,
  output reg  [DATA_W-1:0] o_rd_data,
  output reg               o_rd_valid,
  output reg               o_run_select,
  output reg               o_idle_active,
  output reg  [3:0]        o_slot_sequence_length,
  output reg  [2*PAIRS-1:0] o_input_to_bias_one,
  output reg  [2*PAIRS-1:0] o_input_to_bias_two,
  output reg  [PAIRS-1:0]  o_pair_short,
  output reg  [PAIRS-1:0]  o_pair_differential,
  output reg               o_bias_one_to_supply,
  output reg               o_bias_one_to_ground,
  output reg               o_bias_two_to_supply,
  output reg               o_bias_two_to_ground
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Masked merge keeps reserved bits at zero whatever is written
  function [DATA_W-1:0] merge_write;
    input [DATA_W-1:0] wdata;
    input [DATA_W-1:0] mask;
    begin
      merge_write = wdata & mask;
    end
  endfunction

  function addr_hit;
    input [ADDR_W-1:0] addr;
    input [ADDR_W-1:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  reg  [DATA_W-1:0]  run_control_ff;
  reg  [DATA_W-1:0]  input_idle_state_ff;
  reg  [DATA_W-1:0]  input_pairing_config_ff;
  reg  [DATA_W-1:0]  nxt_run_control;
  reg  [DATA_W-1:0]  nxt_input_idle_state;
  reg  [DATA_W-1:0]  nxt_input_pairing_config;
  reg  [DATA_W-1:0]  nxt_rd_data;

  wire               hit_run;
  wire               hit_idle;
  wire               hit_pair;
  wire [DATA_W-1:0]  run_wdata;
  wire [3:0]         req_slot_len;

  assign hit_run      = addr_hit(i_addr, `IIC_ADDR_RUN_CONTROL);
  assign hit_idle     = addr_hit(i_addr, `IIC_ADDR_IDLE_STATE);
  assign hit_pair     = addr_hit(i_addr, `IIC_ADDR_PAIRING_CFG);
  assign run_wdata    = merge_write(i_wr_data, `IIC_MASK_RUN_CONTROL);
  assign req_slot_len = i_wr_data[`IIC_SLOT_LEN_MSB:`IIC_SLOT_LEN_LSB];

  // ----------------------------------------
  // Write path
  // ----------------------------------------
  always @* begin
    nxt_run_control = run_control_ff;
    if (i_wr_en && hit_run) begin
      nxt_run_control[`IIC_RUN_SELECT_BIT] = run_wdata[`IIC_RUN_SELECT_BIT];
      // Slot counts beyond twelve do not exist; such a field write is dropped
      if (req_slot_len <= `IIC_SLOT_LEN_MAX) begin
        nxt_run_control[`IIC_SLOT_LEN_MSB:`IIC_SLOT_LEN_LSB] = req_slot_len;
      end
    end
  end

  always @* begin
    nxt_input_idle_state = input_idle_state_ff;
    if (i_wr_en && hit_idle) begin
      nxt_input_idle_state = merge_write(i_wr_data, `IIC_MASK_IDLE_STATE);
    end
  end

  always @* begin
    nxt_input_pairing_config = input_pairing_config_ff;
    if (i_wr_en && hit_pair) begin
      nxt_input_pairing_config = merge_write(i_wr_data, `IIC_MASK_PAIRING_CFG);
    end
  end

  // ----------------------------------------
  // Register flops
  // ----------------------------------------
  // One flop group per register keeps each reset value beside its own state
  always @(posedge i_mclk) begin
    if (i_rst) begin
      run_control_ff <= `IIC_RST_RUN_CONTROL;
    end else begin
      run_control_ff <= nxt_run_control;
    end
  end

  always @(posedge i_mclk) begin
    if (i_rst) begin
      input_idle_state_ff <= `IIC_RST_IDLE_STATE;
    end else begin
      input_idle_state_ff <= nxt_input_idle_state;
    end
  end

  always @(posedge i_mclk) begin
    if (i_rst) begin
      input_pairing_config_ff <= `IIC_RST_PAIRING_CFG;
    end else begin
      input_pairing_config_ff <= nxt_input_pairing_config;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Unmapped addresses read as zero rather than stalling the host port
  always @* begin
    nxt_rd_data = {DATA_W{1'b0}};
    if (hit_run) begin
      nxt_rd_data = run_control_ff & `IIC_MASK_RUN_CONTROL;
    end else if (hit_idle) begin
      nxt_rd_data = input_idle_state_ff;
    end else if (hit_pair) begin
      nxt_rd_data = input_pairing_config_ff & `IIC_MASK_PAIRING_CFG;
    end
  end

  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_rd_data  <= {DATA_W{1'b0}};
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        o_rd_data <= nxt_rd_data;
      end
    end
  end

  // ----------------------------------------
  // Field extraction
  // ----------------------------------------
  wire [3:0]         pair_one_idle_code;
  wire [3:0]         pair_two_idle_code;
  wire [3:0]         pair_three_idle_code;
  wire [3:0]         pair_four_idle_code;
  wire               pair_one_differential;
  wire               pair_two_differential;
  wire               pair_three_differential;
  wire               pair_four_differential;
  wire [4*PAIRS-1:0] idle_codes;
  wire [PAIRS-1:0]   diff_bits;
  wire [1:0]         bias_one_code;
  wire [1:0]         bias_two_code;

  assign pair_one_idle_code      = input_idle_state_ff[`IIC_PAIR1_CODE_MSB:`IIC_PAIR1_CODE_LSB];
  assign pair_two_idle_code      = input_idle_state_ff[`IIC_PAIR2_CODE_MSB:`IIC_PAIR2_CODE_LSB];
  assign pair_three_idle_code    = input_idle_state_ff[`IIC_PAIR3_CODE_MSB:`IIC_PAIR3_CODE_LSB];
  assign pair_four_idle_code     = input_idle_state_ff[`IIC_PAIR4_CODE_MSB:`IIC_PAIR4_CODE_LSB];
  assign pair_one_differential   = input_pairing_config_ff[`IIC_DIFF_LSB];
  assign pair_two_differential   = input_pairing_config_ff[`IIC_DIFF_LSB+1];
  assign pair_three_differential = input_pairing_config_ff[`IIC_DIFF_LSB+2];
  assign pair_four_differential  = input_pairing_config_ff[`IIC_DIFF_LSB+3];

  // Field order fixes the pairing; a wider PAIRS needs new fields here too
  assign idle_codes    = {pair_four_idle_code, pair_three_idle_code, pair_two_idle_code, pair_one_idle_code};
  assign diff_bits     = {pair_four_differential, pair_three_differential,
                          pair_two_differential, pair_one_differential};
  assign bias_one_code = input_pairing_config_ff[`IIC_BIAS1_CODE_MSB:`IIC_BIAS1_CODE_LSB];
  assign bias_two_code = input_pairing_config_ff[`IIC_BIAS2_CODE_MSB:`IIC_BIAS2_CODE_LSB];

  // ----------------------------------------
  // Pair decoders
  // ----------------------------------------
  wire [PAIRS-1:0] dec_odd_b1;
  wire [PAIRS-1:0] dec_odd_b2;
  wire [PAIRS-1:0] dec_even_b1;
  wire [PAIRS-1:0] dec_even_b2;
  wire [PAIRS-1:0] dec_short;
  wire [2*PAIRS-1:0] dec_in_b1;
  wire [2*PAIRS-1:0] dec_in_b2;

  genvar g;
  generate
    for (g = 0; g < PAIRS; g = g + 1) begin : g_pair
      iic_pair_decode u_pair (
        .i_code    (idle_codes[4*g+3:4*g]),
        .i_diff    (diff_bits[g]),
        .o_odd_b1  (dec_odd_b1[g]),
        .o_odd_b2  (dec_odd_b2[g]),
        .o_even_b1 (dec_even_b1[g]),
        .o_even_b2 (dec_even_b2[g]),
        .o_short   (dec_short[g])
      );
      // Odd input of pair g is bit 2g, even input is bit 2g+1
      assign dec_in_b1[2*g]   = dec_odd_b1[g];
      assign dec_in_b1[2*g+1] = dec_even_b1[g];
      assign dec_in_b2[2*g]   = dec_odd_b2[g];
      assign dec_in_b2[2*g+1] = dec_even_b2[g];
    end
  endgenerate

  // ----------------------------------------
  // Bias node decoders
  // ----------------------------------------
  wire bias_one_supply;
  wire bias_one_ground;
  wire bias_two_supply;
  wire bias_two_ground;

  iic_bias_decode u_bias_one (
    .i_code      (bias_one_code),
    .o_to_supply (bias_one_supply),
    .o_to_ground (bias_one_ground)
  );

  iic_bias_decode u_bias_two (
    .i_code      (bias_two_code),
    .o_to_supply (bias_two_supply),
    .o_to_ground (bias_two_ground)
  );

  // ----------------------------------------
  // Registered switch controls
  // ----------------------------------------
  // One extra stage keeps switch enables glitch free toward the analog side
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_run_select           <= 1'b0;
      o_idle_active          <= 1'b1;
      o_slot_sequence_length <= 4'h0;
    end else begin
      o_run_select           <= run_control_ff[`IIC_RUN_SELECT_BIT];
      o_idle_active          <= ~run_control_ff[`IIC_RUN_SELECT_BIT];
      o_slot_sequence_length <= run_control_ff[`IIC_SLOT_LEN_MSB:`IIC_SLOT_LEN_LSB];
    end
  end

  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_input_to_bias_one    <= {2*PAIRS{1'b0}};
      o_input_to_bias_two    <= {2*PAIRS{1'b0}};
      o_pair_short           <= {PAIRS{1'b0}};
      o_pair_differential    <= {PAIRS{1'b0}};
    end else begin
      o_input_to_bias_one    <= dec_in_b1;
      o_input_to_bias_two    <= dec_in_b2;
      o_pair_short           <= dec_short;
      o_pair_differential    <= diff_bits;
    end
  end

  // ----------------------------------------
  // Bias node switch controls
  // ----------------------------------------
  // Switches open under reset; the supply tie of code zero follows one edge later
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_bias_one_to_supply   <= 1'b0;
      o_bias_one_to_ground   <= 1'b0;
      o_bias_two_to_supply   <= 1'b0;
      o_bias_two_to_ground   <= 1'b0;
    end else begin
      o_bias_one_to_supply   <= bias_one_supply;
      o_bias_one_to_ground   <= bias_one_ground;
      o_bias_two_to_supply   <= bias_two_supply;
      o_bias_two_to_ground   <= bias_two_ground;
    end
  end

endmodule

// [tb/iic_regs_monitor.sv]
// Assertion checker for the input idle configuration registers
`timescale 1ns/1ps
`include "iic_map.vh"
module iic_regs_monitor #(
  parameter PAIRS  = 4,
  parameter ADDR_W = `IIC_ADDR_W,
  parameter DATA_W = `IIC_DATA_W
) (
  input logic               i_mclk,
  input logic               i_rst,
  input logic               i_wr_en,
  input logic               i_rd_en,
  input logic [ADDR_W-1:0]  i_addr,
  input logic [DATA_W-1:0]  i_wr_data,
  input logic [DATA_W-1:0]  o_rd_data,
  input logic               o_rd_valid,
  input logic               o_run_select,
  input logic               o_idle_active,
  input logic [3:0]         o_slot_sequence_length,
  input logic [2*PAIRS-1:0] o_input_to_bias_one,
  input logic [2*PAIRS-1:0] o_input_to_bias_two,
  input logic [PAIRS-1:0]   o_pair_short,
  input logic [PAIRS-1:0]   o_pair_differential,
  input logic               o_bias_one_to_supply,
  input logic               o_bias_one_to_ground,
  input logic               o_bias_two_to_supply,
  input logic               o_bias_two_to_ground
);
  // ----------------------------------------
  // Helpers and sequences
  // ----------------------------------------
  wire mapped = i_addr == `IIC_ADDR_RUN_CONTROL || i_addr == `IIC_ADDR_IDLE_STATE || i_addr == `IIC_ADDR_PAIRING_CFG;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // A second write right behind would move the outputs again, so only lone writes are tracked
  sequence s_lone_wr(a);
    i_wr_en && i_addr == a ##1 !i_wr_en;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_read_answer: assert property (i_rd_en |=> o_rd_valid)
    else $error("read strobe not answered next cycle");
  a_valid_cause: assert property (o_rd_valid |-> $past(i_rd_en))
    else $error("read valid without a read");
  a_unmapped_read: assert property (i_rd_en && !mapped |=> o_rd_data == 16'h0000)
    else $error("unmapped read not zero");
  a_idle_inverse: assert property (o_idle_active == !o_run_select)
    else $error("idle flag disagrees with run select");
  a_run_update: assert property (s_lone_wr(`IIC_ADDR_RUN_CONTROL) |=> o_run_select == $past(i_wr_data[0], 2))
    else $error("run select not updated from write");
  a_slot_update: assert property ((i_wr_data[11:8] <= 4'hb) and s_lone_wr(`IIC_ADDR_RUN_CONTROL)
    |=> o_slot_sequence_length == $past(i_wr_data[11:8], 2)) else $error("slot length not updated");
  a_slot_bound: assert property (o_slot_sequence_length <= `IIC_SLOT_LEN_MAX)
    else $error("slot length above limit");
  a_diff_update: assert property (s_lone_wr(`IIC_ADDR_PAIRING_CFG)
    |=> o_pair_differential == $past(i_wr_data[3:0], 2))
    else $error("pair mode not updated from write");
  a_short_needs_diff: assert property ((o_pair_short & ~o_pair_differential) == 4'h0)
    else $error("short on a single ended pair");
  a_bias_exclusive: assert property (!(o_bias_one_to_supply && o_bias_one_to_ground)
    && !(o_bias_two_to_supply && o_bias_two_to_ground))
    else $error("bias node tied to supply and ground");
  a_single_bias_tie: assert property ((o_input_to_bias_one & o_input_to_bias_two) == 8'h00)
    else $error("input tied to both bias nodes");
  // A write shows on the switch outputs two edges later, so the cycle before must be write free
  a_hold_no_write: assert property (!$past(i_wr_en) && !$past(i_rst)
    |=> $stable({o_input_to_bias_one, o_input_to_bias_two,
    o_pair_short, o_bias_one_to_supply, o_bias_one_to_ground, o_bias_two_to_supply, o_bias_two_to_ground}))
    else $error("switch outputs moved without a write");
endmodule

bind iic_regs iic_regs_monitor #(.PAIRS(PAIRS), .ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_monitor (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wr_data(i_wr_data),
  .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_run_select(o_run_select), .o_idle_active(o_idle_active),
  .o_slot_sequence_length(o_slot_sequence_length), .o_input_to_bias_one(o_input_to_bias_one),
  .o_input_to_bias_two(o_input_to_bias_two), .o_pair_short(o_pair_short), .o_pair_differential(o_pair_differential),
  .o_bias_one_to_supply(o_bias_one_to_supply), .o_bias_one_to_ground(o_bias_one_to_ground),
  .o_bias_two_to_supply(o_bias_two_to_supply), .o_bias_two_to_ground(o_bias_two_to_ground));

// [tb/iic_regs_tb.sv]
// Self-checking testbench for the input idle configuration registers
`timescale 1ns/1ps
`include "iic_map.vh"
module iic_regs_tb;
  logic        i_mclk, i_rst, i_wr_en, i_rd_en;
  logic [14:0] i_addr;
  logic [15:0] i_wr_data, o_rd_data, word;
  logic        o_rd_valid, o_run_select, o_idle_active, b1s, b1g, b2s, b2g;
  logic [3:0]  o_slot_sequence_length, o_pair_short, o_pair_differential, es, dv;
  logic [7:0]  o_input_to_bias_one, o_input_to_bias_two, e1, e2;
  logic [4:0]  f;
  int          err_count = 0;
  int          samples_checked = 0;

  iic_regs dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_run_select(o_run_select),
    .o_idle_active(o_idle_active), .o_slot_sequence_length(o_slot_sequence_length),
    .o_input_to_bias_one(o_input_to_bias_one), .o_input_to_bias_two(o_input_to_bias_two),
    .o_pair_short(o_pair_short), .o_pair_differential(o_pair_differential), .o_bias_one_to_supply(b1s),
    .o_bias_one_to_ground(b1g), .o_bias_two_to_supply(b2s), .o_bias_two_to_ground(b2g));

  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Returns to the caller once the decoded outputs have had their extra edge
  task automatic wr(input logic [14:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_wr_en   <= 1'b1;
    i_addr    <= a;
    i_wr_data <= d;
    @(posedge i_mclk);
    i_wr_en <= 1'b0;
    @(posedge i_mclk);
    #1;
  endtask
  task automatic rd(input logic [14:0] a, input logic [15:0] exp);
    @(posedge i_mclk);
    i_rd_en <= 1'b1;
    i_addr  <= a;
    @(posedge i_mclk);
    i_rd_en <= 1'b0;
    #1;
    chk("rd_valid", o_rd_valid, 1'b1);
    chk("rd_data", o_rd_data, exp);
  endtask
  // Bits: odd to node one, even to node one, odd to node two, even to node two, short
  function automatic logic [4:0] pexp(input logic [3:0] c, input logic d);
    pexp[0] = c == 4'h2 || c == 4'h4 || c == 4'h5;
    pexp[1] = c == 4'h2 || c == 4'h7 || c == 4'h8;
    pexp[2] = c == 4'h3 || c == 4'h6 || c == 4'h7;
    pexp[3] = c == 4'h3 || c == 4'h5 || c == 4'h9;
    pexp[4] = d && c >= 4'h1 && c <= 4'h3;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    i_rst     = 1'b1;
    i_wr_en   = 1'b0;
    i_rd_en   = 1'b0;
    i_addr    = 15'h0000;
    i_wr_data = 16'h0000;
    repeat (12) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(`IIC_ADDR_RUN_CONTROL, 16'h0000);
    rd(`IIC_ADDR_IDLE_STATE, 16'h0000);
    rd(`IIC_ADDR_PAIRING_CFG, 16'h0000);
    chk("idle_active", o_idle_active, 1'b1);
    chk("bias_reset", {b1s, b1g, b2s, b2g}, 4'ha);
    // Each pair gets a different code so a swapped field shows up
    for (int d = 0; d < 2; d++) begin
      dv = d ? 4'ha : 4'h5;
      wr(`IIC_ADDR_PAIRING_CFG, {12'h000, dv});
      chk("pair_diff", o_pair_differential, dv);
      for (int c = 0; c < 16; c++) begin
        word = {c[3:0] + 4'h3, c[3:0] + 4'h2, c[3:0] + 4'h1, c[3:0]};
        wr(`IIC_ADDR_IDLE_STATE, word);
        for (int p = 0; p < 4; p++) begin
          f = pexp(word[4*p+:4], dv[p]);
          e1[2*p+:2] = f[1:0];
          e2[2*p+:2] = f[3:2];
          es[p] = f[4];
        end
        rd(`IIC_ADDR_IDLE_STATE, word);
        chk("to_bias_one", o_input_to_bias_one, e1);
        chk("to_bias_two", o_input_to_bias_two, e2);
        chk("pair_short", o_pair_short, es);
      end
    end
    for (int b = 0; b < 4; b++) begin
      word = {8'h00, b[1:0], ~b[1:0], 4'h0};
      wr(`IIC_ADDR_PAIRING_CFG, word);
      rd(`IIC_ADDR_PAIRING_CFG, word);
      chk("bias_two", {b2s, b2g}, {b[1:0] == 2'h0, b[1:0] == 2'h1});
      chk("bias_one", {b1s, b1g}, {b[1:0] == 2'h3, b[1:0] == 2'h2});
    end
    wr(`IIC_ADDR_RUN_CONTROL, 16'hfb01);
    rd(`IIC_ADDR_RUN_CONTROL, 16'h0b01);
    chk("run", {o_run_select, o_idle_active, o_slot_sequence_length}, 6'h2b);
    wr(`IIC_ADDR_RUN_CONTROL, 16'h0c00);
    rd(`IIC_ADDR_RUN_CONTROL, 16'h0b00);
    chk("run", {o_run_select, o_idle_active, o_slot_sequence_length}, 6'h1b);
    wr(`IIC_ADDR_PAIRING_CFG, 16'hffff);
    rd(`IIC_ADDR_PAIRING_CFG, 16'h00ff);
    wr(`IIC_ADDR_IDLE_STATE, 16'hffff);
    chk("undef_code", {o_input_to_bias_one, o_input_to_bias_two}, 16'h0000);
    chk("undef_short", {12'h000, o_pair_short}, 16'h0000);
    wr(15'h0022, 16'hffff);
    rd(15'h0022, 16'h0000);
    wr(`IIC_ADDR_RUN_CONTROL, 16'h0001);
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    #1;
    chk("rst_outs", {o_run_select, o_slot_sequence_length, o_pair_differential, b1s, b1g, b2s, b2g}, 16'h0);
    chk("rst_idle", o_idle_active, 1'b1);
    @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(`IIC_ADDR_PAIRING_CFG, 16'h0000);
    rd(`IIC_ADDR_RUN_CONTROL, 16'h0000);
    tally_and_finish();
  end

  // Scenarios need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_mclk);
    err_count++;
    tally_and_finish();
  end
endmodule
